// ---- overcurrent_pkg.sv ----
// Package: types, settings and timing constants of the instantaneous overcurrent block
package overcurrent_pkg;

    // ----------------------------------------------------------------
    // Widths and setting limits
    // ----------------------------------------------------------------
    localparam int SAMPLE_WIDTH  = 16;
    localparam int SETTING_WIDTH = 12;
    localparam logic [SETTING_WIDTH-1:0] START_MIN     = 12'h014; // 20 %
    localparam logic [SETTING_WIDTH-1:0] START_MAX     = 12'hBB8; // 3000 %
    localparam logic [SETTING_WIDTH-1:0] START_DEFAULT = 12'h0C8; // 200 %

    // Reset ratio 0.85 expressed as 17/20
    localparam int RESET_NUM = 17;
    localparam int RESET_DEN = 20;

    // ----------------------------------------------------------------
    // Timing figures
    // ----------------------------------------------------------------
    localparam int CLK_HZ          = 50_000_000;
    localparam int PEAK_OP_TIME_MS = 15;
    localparam int FUND_OP_TIME_MS = 25;
    // Longest times round down to whole cycles
    localparam int PEAK_OP_CYCLES  = (CLK_HZ / 1000) * PEAK_OP_TIME_MS;
    localparam int FUND_OP_CYCLES  = (CLK_HZ / 1000) * FUND_OP_TIME_MS;

    // ----------------------------------------------------------------
    // Operation mode
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF  = 2'h0,
        MODE_PEAK = 2'h1,
        MODE_FUND = 2'h2
    } op_mode_type;

    // One measured quantity per phase
    typedef struct packed {
        logic [SAMPLE_WIDTH-1:0] phase_a;
        logic [SAMPLE_WIDTH-1:0] phase_b;
        logic [SAMPLE_WIDTH-1:0] phase_c;
    } phase_values_type;

    // Trip outputs
    typedef struct packed {
        logic       any_phase_trip;
        logic [2:0] phase_trip;
    } trip_set_type;

    // Event pulses, bit 3 is the general trip, bits 2..0 phases c..a
    typedef struct packed {
        logic [3:0] on_event;
        logic [3:0] off_event;
    } trip_events_type;

endpackage

// ---- instant_overcurrent_function.sv ----
// Instantaneous overcurrent decision for three phases with trip events
module instant_overcurrent_function
    import overcurrent_pkg::*;
#(
    parameter int PEAK_WINDOW = 1000 // Samples over which a peak is held
) (
    input  wire logic                                  clk,
    input  wire logic                                  rst_n,
    input  wire overcurrent_pkg::op_mode_type          op_mode,
    input  wire logic [overcurrent_pkg::SETTING_WIDTH-1:0] start_current,
    input  wire logic                                  function_inhibit,
    input  wire logic                                  threshold_doubler,
    input  wire logic                                  sample_valid,
    input  wire overcurrent_pkg::phase_values_type     sample_abs,
    input  wire overcurrent_pkg::phase_values_type     fundamental_rms,
    output      logic                                  phase_a_trip,
    output      logic                                  phase_b_trip,
    output      logic                                  phase_c_trip,
    output      logic                                  any_phase_trip,
    output      overcurrent_pkg::trip_events_type      trip_events
);
    import overcurrent_pkg::*;

    localparam int CW = $clog2(PEAK_WINDOW + 1);
    localparam int PW = SAMPLE_WIDTH + 8; // Room for percent products

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0][SAMPLE_WIDTH-1:0] peak;
        logic [2:0][SAMPLE_WIDTH-1:0] peak_run;
        logic [CW-1:0]                window_count;
        trip_set_type                 trips;
        trip_events_type              events;
    } state_type;

    state_type state;
    state_type next_state;

    // Clamp start setting into its legal range
    function automatic logic [SETTING_WIDTH-1:0] clamp_start(input logic [SETTING_WIDTH-1:0] s);
        if (s < START_MIN) begin
            return START_MIN;
        end else if (s > START_MAX) begin
            return START_MAX;
        end
        return s;
    endfunction

    logic [SETTING_WIDTH-1:0] start_eff;
    logic [PW-1:0]            threshold;      // Percent of nominal, x1 or x2
    logic [2:0][SAMPLE_WIDTH-1:0] sample_vec;
    logic [2:0][SAMPLE_WIDTH-1:0] fund_vec;
    logic [2:0][SAMPLE_WIDTH-1:0] measured;
    logic [2:0]               pickup;
    logic [2:0]               dropout;
    logic                     enabled;

    // ----------------------------------------------------------------
    // Setting handling
    // ----------------------------------------------------------------
    // Measured values are in percent of nominal, same scale as the setting
    assign start_eff  = clamp_start(start_current);
    assign threshold  = threshold_doubler ? {{(PW-SETTING_WIDTH-1){1'b0}}, start_eff, 1'b0}
                                          : {{(PW-SETTING_WIDTH){1'b0}}, start_eff};
    assign enabled    = (op_mode != MODE_OFF) && !function_inhibit;
    assign sample_vec = {sample_abs.phase_c, sample_abs.phase_b, sample_abs.phase_a};
    assign fund_vec   = {fundamental_rms.phase_c, fundamental_rms.phase_b,
                         fundamental_rms.phase_a};

    // ----------------------------------------------------------------
    // Per-phase decision
    // ----------------------------------------------------------------
    // Dropout compares 20*I against 17*threshold to avoid a divider
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            logic [PW-1:0] meas_wide;
            assign measured[g] = (op_mode == MODE_PEAK) ? state.peak[g] : fund_vec[g];
            assign meas_wide   = {{(PW-SAMPLE_WIDTH){1'b0}}, measured[g]};
            assign pickup[g]   = meas_wide > threshold;
            assign dropout[g]  = (meas_wide * PW'(RESET_DEN))
                                 < (threshold * PW'(RESET_NUM));
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        // Peak hold per phase, refreshed each window so it can fall again
        if (sample_valid) begin
            for (int p = 0; p < 3; p++) begin
                if (state.window_count == '0) begin
                    next_state.peak[p]     = (sample_vec[p] > state.peak_run[p]) ?
                                             sample_vec[p] : state.peak_run[p];
                    next_state.peak_run[p] = '0;
                end else begin
                    if (sample_vec[p] > state.peak_run[p]) begin
                        next_state.peak_run[p] = sample_vec[p];
                    end
                    // A new high is seen at once so the pickup is not delayed
                    if (sample_vec[p] > state.peak[p]) begin
                        next_state.peak[p] = sample_vec[p];
                    end
                end
            end
            next_state.window_count = (state.window_count == '0) ?
                                      CW'(PEAK_WINDOW - 1) : state.window_count - 1'b1;
        end
        // Trip with hysteresis; forced low while disabled
        for (int p = 0; p < 3; p++) begin
            if (!enabled) begin
                next_state.trips.phase_trip[p] = 1'b0;
            end else if (pickup[p]) begin
                next_state.trips.phase_trip[p] = 1'b1;
            end else if (dropout[p]) begin
                next_state.trips.phase_trip[p] = 1'b0;
            end
        end
        next_state.trips.any_phase_trip = |next_state.trips.phase_trip;
        // Edge events on the four trip outputs
        next_state.events.on_event  = next_state.trips & ~state.trips;
        next_state.events.off_event = ~next_state.trips & state.trips;
    end

    // Single register for the whole state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign phase_a_trip   = state.trips.phase_trip[0];
    assign phase_b_trip   = state.trips.phase_trip[1];
    assign phase_c_trip   = state.trips.phase_trip[2];
    assign any_phase_trip = state.trips.any_phase_trip;
    assign trip_events    = state.events;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_over_a;
        enabled && pickup[0];
    endsequence

    a_general_trip_or: assert property (@(posedge clk) disable iff (!rst_n)
        any_phase_trip == (phase_a_trip | phase_b_trip | phase_c_trip))
        else $error("general trip differs from OR of phases");
    a_off_holds_low: assert property (@(posedge clk) disable iff (!rst_n)
        op_mode == MODE_OFF |=> !any_phase_trip && !phase_a_trip)
        else $error("trip while operation off");
    a_inhibit_no_trip: assert property (@(posedge clk) disable iff (!rst_n)
        function_inhibit |=> !(phase_a_trip || phase_b_trip || phase_c_trip))
        else $error("trip while inhibited");
    a_pickup_immediate: assert property (@(posedge clk) disable iff (!rst_n)
        s_over_a |=> phase_a_trip)
        else $error("phase a did not pick up next cycle");
    a_phase_own_only: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(phase_b_trip) |-> $past(pickup[1]))
        else $error("phase b trip without its own pickup");
    a_double_threshold: assert property (@(posedge clk) disable iff (!rst_n)
        threshold_doubler |-> threshold == {start_eff, 1'b0})
        else $error("doubled threshold wrong");
    a_setting_range: assert property (@(posedge clk) disable iff (!rst_n)
        start_eff >= START_MIN && start_eff <= START_MAX)
        else $error("effective start out of range");
    a_event_on_rise: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(any_phase_trip) |-> trip_events.on_event[3] && !trip_events.off_event[3])
        else $error("missing on event for general trip");
    a_event_off_fall: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(phase_a_trip) |-> trip_events.off_event[0])
        else $error("missing off event for phase a");
    a_hold_above_drop: assert property (@(posedge clk) disable iff (!rst_n)
        phase_c_trip && enabled && !dropout[2] |=> phase_c_trip)
        else $error("phase c dropped above reset level");
    a_peak_tracks: assert property (@(posedge clk) disable iff (!rst_n)
        sample_valid |=> state.peak[0] >= $past(sample_vec[0]))
        else $error("peak below latest sample");

endmodule

// ---- front_end.sv ----
// Model of the current measurement front end that feeds the overcurrent block
module front_end
    import overcurrent_pkg::*;
#(
    parameter int SAMPLE_GAP = 4 // Cycles between samples, shortened for simulation
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire overcurrent_pkg::phase_values_type level,
    output      logic                              sample_valid,
    output      overcurrent_pkg::phase_values_type sample_abs,
    output      overcurrent_pkg::phase_values_type fundamental_rms
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap;
    // Samples on a fixed cadence; between them the sample bus carries junk,
    // so a peak stage that reads it without sample_valid trips by mistake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 0;
            sample_valid <= 1'b0;
            sample_abs <= '0;
            fundamental_rms <= '0;
        end else begin
            gap <= (gap == SAMPLE_GAP - 1) ? 0 : gap + 1;
            sample_valid <= (gap == SAMPLE_GAP - 1);
            sample_abs <= (gap == SAMPLE_GAP - 1) ? level : ~level;
            fundamental_rms <= level;
        end
    end
endmodule

// ---- tb.sv ----
// Self-checking bench of the instantaneous overcurrent block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import overcurrent_pkg::*;
    localparam int GAP = 4;
    localparam int F   = 3;           // Fundamental path answers one cycle on
    localparam int P   = 2 * GAP + 3; // Two sample gaps plus the front end, peak and trip registers
    localparam int PD  = 8 * GAP + 8; // Peak hold must refresh before dropout
    logic                     clk   = 1'b0;
    logic                     rst_n;
    op_mode_type              m     = MODE_OFF;
    logic [SETTING_WIDTH-1:0] st    = START_DEFAULT;
    logic                     inh   = 1'b0;
    logic                     dbl   = 1'b0;
    phase_values_type         lvl   = '0;
    phase_values_type         s_abs;
    phase_values_type         s_rms;
    logic                     s_vld;
    logic                     trip_a, trip_b, trip_c, trip_any;
    trip_events_type          ev;
    int                       fails = 0;
    int                       n_checks = 0;
    int                       cycles = 0;
    int                       on_seen[4] = '{default: 0};
    int                       off_seen[4] = '{default: 0};
    int                       on_exp[4] = '{default: 0};
    int                       off_exp[4] = '{default: 0};
    logic [3:0]               exp_state = '0;

    front_end #(.SAMPLE_GAP(GAP)) i_front (.clk(clk), .rst_n(rst_n), .level(lvl),
        .sample_valid(s_vld), .sample_abs(s_abs), .fundamental_rms(s_rms));
    instant_overcurrent_function #(.PEAK_WINDOW(4)) i_dut (.clk(clk), .rst_n(rst_n),
        .op_mode(m), .start_current(st), .function_inhibit(inh), .threshold_doubler(dbl),
        .sample_valid(s_vld), .sample_abs(s_abs), .fundamental_rms(s_rms),
        .phase_a_trip(trip_a), .phase_b_trip(trip_b), .phase_c_trip(trip_c),
        .any_phase_trip(trip_any), .trip_events(ev));

    // Clock at 50 MHz
    initial forever #10 clk = ~clk;

    // Tally event pulses; the ceiling cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        for (int i = 0; i < 4; i++) begin
            on_seen[i] <= on_seen[i] + (ev.on_event[i] === 1'b1);
            off_seen[i] <= off_seen[i] + (ev.off_event[i] === 1'b1);
        end
        if (cycles == 5000) begin
            fails++;
            final_report();
        end
    end

    // Drive one setting, settle, then judge trips and the events they imply
    task automatic step(input op_mode_type md, input int s, input logic d, input logic k,
                        input int a, input int b, input int c, input int lim,
                        input logic [2:0] exp);
        logic [3:0] want;
        logic [3:0] seen;
        want = {|exp, exp};
        @(posedge clk);
        lvl.phase_a <= SAMPLE_WIDTH'(a);
        lvl.phase_b <= SAMPLE_WIDTH'(b);
        lvl.phase_c <= SAMPLE_WIDTH'(c);
        // Levels lead by a cycle: the front end registers them, and an old level
        // meeting a new setting for one cycle could latch a trip in the hysteresis band
        @(posedge clk);
        m <= md;
        st <= SETTING_WIDTH'(s);
        dbl <= d;
        inh <= k;
        repeat (lim) @(negedge clk);
        seen = {trip_any, trip_c, trip_b, trip_a};
        n_checks++;
        if (seen !== want) begin
            fails++;
            $display("MISMATCH trips expected %b seen %b", want, seen);
        end
        n_checks++;
        // Compared bit by bit so that no aggregate compare or %p is needed
        for (int i = 0; i < 4; i++) begin
            on_exp[i] += int'(want[i] & ~exp_state[i]);
            off_exp[i] += int'(~want[i] & exp_state[i]);
            if (on_seen[i] != on_exp[i] || off_seen[i] != off_exp[i]) begin
                fails++;
                $display("MISMATCH events bit %0d expected on %0d off %0d seen on %0d off %0d",
                         i, on_exp[i], off_exp[i], on_seen[i], off_seen[i]);
            end
        end
        exp_state = want;
    endtask

    // Fundamental mode shorthand
    task automatic fund(input int s, input logic d, input logic k, input int a, input int b,
                        input int c, input logic [2:0] exp);
        step(MODE_FUND, s, d, k, a, b, c, F, exp);
    endtask

    task automatic t_off();
        step(MODE_OFF, 200, 1'b0, 1'b0, 500, 500, 500, P, 3'b000);
        fund(200, 1'b0, 1'b0, 500, 500, 500, 3'b111);
        step(MODE_OFF, 200, 1'b0, 1'b0, 3000, 0, 3000, PD, 3'b000);
        $display("test operation_off done");
    endtask

    task automatic t_phases();
        fund(200, 1'b0, 1'b0, 200, 200, 200, 3'b000);
        for (int p = 0; p < 3; p++) begin
            fund(200, 1'b0, 1'b0, p == 0 ? 201 : 0, p == 1 ? 201 : 0, p == 2 ? 201 : 0,
                 3'(1 << p));
            fund(200, 1'b0, 1'b0, 0, 0, 0, 3'b000);
        end
        fund(200, 1'b0, 1'b0, 250, 0, 201, 3'b101);
        fund(200, 1'b0, 1'b0, 171, 0, 0, 3'b001);
        fund(200, 1'b0, 1'b0, 169, 0, 0, 3'b000);
        $display("test phases_and_hysteresis done");
    endtask

    task automatic t_double_inhibit();
        fund(200, 1'b1, 1'b0, 400, 0, 0, 3'b000);
        fund(200, 1'b1, 1'b0, 401, 0, 0, 3'b001);
        fund(200, 1'b1, 1'b0, 341, 0, 0, 3'b001);
        fund(200, 1'b1, 1'b0, 339, 0, 0, 3'b000);
        fund(200, 1'b0, 1'b0, 500, 500, 500, 3'b111);
        fund(200, 1'b0, 1'b1, 500, 500, 500, 3'b000);
        fund(200, 1'b0, 1'b0, 500, 500, 500, 3'b111);
        fund(200, 1'b0, 1'b0, 0, 0, 0, 3'b000);
        $display("test double_and_inhibit done");
    endtask

    task automatic t_start();
        fund(20, 1'b0, 1'b0, 0, 20, 0, 3'b000);
        fund(20, 1'b0, 1'b0, 0, 21, 0, 3'b010);
        fund(200, 1'b0, 1'b0, 0, 0, 0, 3'b000);
        fund(3000, 1'b0, 1'b0, 0, 0, 3000, 3'b000);
        fund(3000, 1'b0, 1'b0, 0, 0, 3001, 3'b100);
        fund(200, 1'b0, 1'b0, 0, 0, 0, 3'b000);
        $display("test start_range done");
    endtask

    task automatic t_peak();
        // Let the held peaks settle while off, so old highs cannot trip on entry
        step(MODE_OFF, 200, 1'b0, 1'b0, 200, 0, 0, PD, 3'b000);
        step(MODE_PEAK, 200, 1'b0, 1'b0, 200, 0, 0, P, 3'b000);
        step(MODE_PEAK, 200, 1'b0, 1'b0, 0, 401, 0, P, 3'b010);
        step(MODE_PEAK, 200, 1'b0, 1'b0, 0, 401, 401, P, 3'b110);
        step(MODE_PEAK, 200, 1'b0, 1'b0, 0, 0, 0, PD, 3'b000);
        $display("test peak_mode done");
    endtask

    // Closing report and verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence: reset held for 12 cycles, then the scenarios
    initial begin
        // Falling edge from unknown so every asynchronous reset branch runs
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_off();
        t_phases();
        t_double_inhibit();
        t_start();
        t_peak();
        final_report();
    end
endmodule
